// [include/pmtc_defs.vh]
// Constants for the periodic modulo tick counter: register map, fields, resets.
// Included by the design files; holds definitions only.
`ifndef PMTC_DEFS_VH
`define PMTC_DEFS_VH

// ==================================================
// Register byte offsets
`define PMTC_OFF_CTRL      8'h00
`define PMTC_OFF_MODULO    8'h04
`define PMTC_OFF_COUNT     8'h08
`define PMTC_OFF_IRQ_MASK  8'h0c

// ==================================================
// Control/status field positions
`define PMTC_SRC_LSB       12
`define PMTC_SRC_MSB       13
`define PMTC_PS_LSB        8
`define PMTC_PS_MSB        10
`define PMTC_FLAG_BIT      7
`define PMTC_IRQEN_BIT     6
`define PMTC_TOGEN_BIT     4

// ==================================================
// Reset values and encodings
`define PMTC_RST_SRC       2'h0
`define PMTC_RST_PS        3'h0
`define PMTC_RST_MOD       16'h0000
`define PMTC_RST_CNT       16'h0000
`define PMTC_PS_OFF        3'h0

// ==================================================
// Divider terminal counts (divide-by minus one)
`define PMTC_DIVW          10
`define PMTC_DIV_1         10'h000
`define PMTC_DIV_2         10'h001
`define PMTC_DIV_4         10'h003
`define PMTC_DIV_8         10'h007
`define PMTC_DIV_16        10'h00f
`define PMTC_DIV_32        10'h01f
`define PMTC_DIV_64        10'h03f
`define PMTC_DIV_128       10'h07f
`define PMTC_DIV_256       10'h0ff
`define PMTC_DIV_512       10'h1ff
`define PMTC_DIV_1024      10'h3ff
`define PMTC_DIV_100       10'h063
`define PMTC_DIV_1000      10'h3e7
// 2048 needs one more bit than the others; handled as 1024 with a half stage
`define PMTC_DIV_2048_HALF 10'h3ff

`endif

// [design/pmtc_prescaler.v]
// Prescaler: divides the selected, already synchronised source edges.
// Assumes src_edge is a one-cycle pulse in the CLOCK domain.
`timescale 1ns/1ps
`include "pmtc_defs.vh"

module pmtc_prescaler (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       clear,
    input  wire       src_edge,
    input  wire [2:0] ps_sel,
    input  wire       src_bit0,
    output reg        tick
);

    reg [`PMTC_DIVW-1:0] div_r;
    reg                  half_r;
    reg [`PMTC_DIVW-1:0] term;
    reg                  need_half;
    wire                 at_term;

    // ==================================================
    // Terminal count lookup
    always @* begin
        need_half = 1'b0;
        case ({src_bit0, ps_sel})
            4'h1: term = `PMTC_DIV_1;
            4'h2: term = `PMTC_DIV_2;
            4'h3: term = `PMTC_DIV_4;
            4'h4: term = `PMTC_DIV_8;
            4'h5: term = `PMTC_DIV_16;
            4'h6: term = `PMTC_DIV_32;
            4'h7: term = `PMTC_DIV_64;
            4'h9: term = `PMTC_DIV_128;
            4'ha: term = `PMTC_DIV_256;
            4'hb: term = `PMTC_DIV_512;
            4'hc: term = `PMTC_DIV_1024;
            4'hd: begin
                term      = `PMTC_DIV_2048_HALF;
                need_half = 1'b1;
            end
            4'he: term = `PMTC_DIV_100;
            4'hf: term = `PMTC_DIV_1000;
            default: term = `PMTC_DIV_1;
        endcase
    end

    assign at_term = (div_r == term) && (!need_half || half_r);

    // ==================================================
    // Divider, idle while the selection is off
    always @(posedge clk) begin
        if (!rst_n || clear || ps_sel == `PMTC_PS_OFF) begin
            div_r  <= {`PMTC_DIVW{1'b0}};
            half_r <= 1'b0;
            tick   <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_edge) begin
                if (at_term) begin
                    div_r  <= {`PMTC_DIVW{1'b0}};
                    half_r <= 1'b0;
                    tick   <= 1'b1;
                end else if (div_r == term) begin
                    div_r  <= {`PMTC_DIVW{1'b0}};
                    half_r <= 1'b1;
                end else begin
                    div_r <= div_r + 1'b1;
                end
            end
        end
    end

endmodule // pmtc_prescaler

// [design/pmtc_top.v]
// Periodic modulo tick counter with classic Wishbone register slave.
// Assumes source clocks arrive as levels sampled by CLOCK (10 MHz), each
// well below half the CLOCK rate; the bus clock source is CLOCK itself.
`timescale 1ns/1ps
`include "pmtc_defs.vh"

module pmtc_top (
    input  wire        CLOCK,
    input  wire        RESET_N,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    input  wire        EXT_OSC_CLK,
    input  wire        LOW_POWER_OSC_CLK,
    input  wire        INTERNAL_REF_CLK,
    output wire        TICK_IRQ,
    output reg         TOGGLE_OUT
);

    // ==================================================
    // Registers
    reg  [1:0]  source_select_r;
    reg  [2:0]  prescale_select_r;
    reg         tick_flag_r;
    reg         tick_irq_enable_r;
    reg         toggle_out_enable_r;
    reg         irq_mask_r;
    reg  [15:0] wrap_value_r;
    reg  [15:0] wrap_active_r;
    reg  [15:0] main_count_r;
    reg  [2:0]  sync_a_r;
    reg  [2:0]  sync_b_r;
    reg  [2:0]  sync_prev_r;
    reg         src_level;
    reg         src_prev;
    reg         src_edge;
    reg  [31:0] rd_data;
    reg         clear_nxt;
    reg         load_mod_nxt;
    reg  [1:0]  src_wr;
    reg  [2:0]  ps_wr;

    wire        bus_req;
    wire        wr_ctrl;
    wire        presc_tick;
    wire        wrap;
    wire        flag_clr;

    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_ctrl = bus_req && WB_WE_I && (WB_ADR_I == `PMTC_OFF_CTRL);

    // ==================================================
    // Source synchronisers
    // Two synchroniser flops per source plus a history flop; the second and third stages feed the edge detector.
    genvar gi;
    wire [2:0] raw_src;
    assign raw_src = {INTERNAL_REF_CLK, LOW_POWER_OSC_CLK, EXT_OSC_CLK};
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge CLOCK) begin
                if (!RESET_N) begin
                    sync_a_r[gi]    <= 1'b0;
                    sync_b_r[gi]    <= 1'b0;
                    sync_prev_r[gi] <= 1'b0;
                end else begin
                    sync_a_r[gi]    <= raw_src[gi];
                    sync_b_r[gi]    <= sync_a_r[gi];
                    sync_prev_r[gi] <= sync_b_r[gi];
                end
            end
        end
    endgenerate

    // Bus clock source yields an edge every cycle.
    always @* begin
        src_level = sync_b_r[0];
        src_prev  = sync_prev_r[0];
        case (source_select_r)
            2'h0: begin
                src_level = sync_b_r[0];
                src_prev  = sync_prev_r[0];
            end
            2'h1: begin
                src_level = sync_b_r[1];
                src_prev  = sync_prev_r[1];
            end
            2'h2: begin
                src_level = sync_b_r[2];
                src_prev  = sync_prev_r[2];
            end
            default: begin
                src_level = 1'b1;
                src_prev  = 1'b0;
            end
        endcase
        src_edge = src_level && !src_prev;
    end

    // ==================================================
    // Control write decode
    always @* begin
        src_wr       = source_select_r;
        ps_wr        = prescale_select_r;
        clear_nxt    = 1'b0;
        load_mod_nxt = 1'b0;
        if (wr_ctrl && WB_SEL_I[1]) begin
            src_wr = WB_DAT_I[`PMTC_SRC_MSB:`PMTC_SRC_LSB];
            ps_wr  = WB_DAT_I[`PMTC_PS_MSB:`PMTC_PS_LSB];
            if (src_wr != source_select_r)
                clear_nxt = 1'b1;
            if (ps_wr != prescale_select_r)
                clear_nxt = 1'b1;
            if (ps_wr != `PMTC_PS_OFF)
                load_mod_nxt = 1'b1;
        end
    end

    pmtc_prescaler u_presc (
        .clk      (CLOCK),
        .rst_n    (RESET_N),
        .clear    (clear_nxt),
        .src_edge (src_edge),
        .ps_sel   (prescale_select_r),
        .src_bit0 (source_select_r[0]),
        .tick     (presc_tick)
    );

    // ==================================================
    // Counter and comparator
    // Modulo zero makes every tick a wrap, so the flag sets each tick.
    assign wrap = presc_tick && (main_count_r == wrap_active_r);

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            main_count_r  <= `PMTC_RST_CNT;
            wrap_active_r <= `PMTC_RST_MOD;
        end else if (clear_nxt) begin
            main_count_r <= `PMTC_RST_CNT;
            if (load_mod_nxt)
                wrap_active_r <= wrap_value_r;
        end else begin
            if (load_mod_nxt)
                wrap_active_r <= wrap_value_r;
            if (wrap) begin
                main_count_r  <= `PMTC_RST_CNT;
                wrap_active_r <= wrap_value_r;
            end else if (presc_tick) begin
                main_count_r <= main_count_r + 16'h0001;
            end
        end
    end

    // ==================================================
    // Control, flag, interrupt and toggle output
    assign flag_clr = wr_ctrl && WB_SEL_I[0] && WB_DAT_I[`PMTC_FLAG_BIT];

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            source_select_r     <= `PMTC_RST_SRC;
            prescale_select_r   <= `PMTC_RST_PS;
            tick_flag_r         <= 1'b0;
            tick_irq_enable_r   <= 1'b0;
            toggle_out_enable_r <= 1'b0;
            irq_mask_r          <= 1'b0;
            wrap_value_r        <= `PMTC_RST_MOD;
            TOGGLE_OUT          <= 1'b0;
        end else begin
            source_select_r   <= src_wr;
            prescale_select_r <= ps_wr;
            if (wr_ctrl && WB_SEL_I[0]) begin
                tick_irq_enable_r   <= WB_DAT_I[`PMTC_IRQEN_BIT];
                toggle_out_enable_r <= WB_DAT_I[`PMTC_TOGEN_BIT];
            end
            // A wrap in the clearing cycle keeps the flag set.
            if (wrap)
                tick_flag_r <= 1'b1;
            else if (flag_clr)
                tick_flag_r <= 1'b0;
            if (wrap && toggle_out_enable_r)
                TOGGLE_OUT <= !TOGGLE_OUT;
            if (bus_req && WB_WE_I && WB_ADR_I == `PMTC_OFF_MODULO) begin
                if (WB_SEL_I[0])
                    wrap_value_r[7:0] <= WB_DAT_I[7:0];
                if (WB_SEL_I[1])
                    wrap_value_r[15:8] <= WB_DAT_I[15:8];
            end
            if (bus_req && WB_WE_I && WB_ADR_I == `PMTC_OFF_IRQ_MASK && WB_SEL_I[0])
                irq_mask_r <= WB_DAT_I[`PMTC_FLAG_BIT];
        end
    end

    // Read of control clears nothing: the flag is cleared by writing one.
    assign TICK_IRQ = tick_flag_r && tick_irq_enable_r && !irq_mask_r;

    // ==================================================
    // Wishbone read path and acknowledge
    always @* begin
        rd_data = 32'h0000_0000;
        case (WB_ADR_I)
            `PMTC_OFF_CTRL: begin
                rd_data[`PMTC_SRC_MSB:`PMTC_SRC_LSB] = source_select_r;
                rd_data[`PMTC_PS_MSB:`PMTC_PS_LSB]   = prescale_select_r;
                rd_data[`PMTC_FLAG_BIT]              = tick_flag_r;
                rd_data[`PMTC_IRQEN_BIT]             = tick_irq_enable_r;
                rd_data[`PMTC_TOGEN_BIT]             = toggle_out_enable_r;
            end
            `PMTC_OFF_MODULO:   rd_data[15:0] = wrap_value_r;
            `PMTC_OFF_COUNT:    rd_data[15:0] = main_count_r;
            `PMTC_OFF_IRQ_MASK: rd_data[`PMTC_FLAG_BIT] = irq_mask_r;
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    // Count is read whole in one access, so low-before-high order holds.
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_req && !WB_WE_I)
                WB_DAT_O <= rd_data;
        end
    end

endmodule // pmtc_top

// [tb/pmtc_monitor.sv]
// Checker for pmtc_top: bus handshake, zero upper halves, interrupt causes.
// Sees only top-level ports; bound to every pmtc_top at the foot of this file.
`timescale 1ns/1ps
module pmtc_monitor (
    input wire        CLOCK,
    input wire        RESET_N,
    input wire        WB_CYC_I,
    input wire        WB_STB_I,
    input wire        WB_WE_I,
    input wire [7:0]  WB_ADR_I,
    input wire [3:0]  WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire [31:0] WB_DAT_O,
    input wire        WB_ACK_O,
    input wire        TICK_IRQ,
    input wire        TOGGLE_OUT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // ==================================================
    // Helpers
    wire        req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire        wr_req = req && WB_WE_I;
    wire [15:0] wr_lo  = WB_DAT_I[15:0];
    sequence s_mod_wr;
        wr_req && WB_ADR_I == 8'h04 && WB_SEL_I[1:0] == 2'h3;
    endsequence
    sequence s_mod_rd;
        req && !WB_WE_I && WB_ADR_I == 8'h04;
    endsequence
    // ==================================================
    // Properties
    property p_ack_pulse;
        req |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a single pulse after request");
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(req);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_upper_zero;
        req && !WB_WE_I && (WB_ADR_I == 8'h04 || WB_ADR_I == 8'h08) |=> WB_DAT_O[31:16] == 16'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper half of read not zero");
    // Write, release, idle, then read back: a fixed three-edge gap
    property p_mod_back;
        s_mod_wr ##3 s_mod_rd |=> WB_DAT_O[15:0] == $past(wr_lo, 4);
    endproperty
    a_mod_back: assert property (p_mod_back)
        else $error("modulo readback differs from write");
    property p_reset_quiet;
        $rose(RESET_N) |-> !TICK_IRQ && !TOGGLE_OUT && !WB_ACK_O;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    property p_irq_fall;
        $fell(TICK_IRQ) |-> $past(wr_req);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
    property p_irq_off;
        wr_req && WB_ADR_I == 8'h00 && WB_SEL_I[0] && !WB_DAT_I[6] |=> !TICK_IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt high while disabled");
    property p_irq_mask;
        wr_req && WB_ADR_I == 8'h0c && WB_SEL_I[0] && WB_DAT_I[7] |=> !TICK_IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high while masked");
endmodule // pmtc_monitor

bind pmtc_top pmtc_monitor pmtc_monitor_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .TICK_IRQ(TICK_IRQ), .TOGGLE_OUT(TOGGLE_OUT));

// [tb/pmtc_top_bench.sv]
// Self-checking bench for pmtc_top with an integer model of the counter.
// Assumes the one-cycle Wishbone answer and slow source levels of the note.
`timescale 1ns/1ps
module pmtc_top_bench;
    reg         clock = 1'b0;
    reg         reset_n = 1'b0;
    reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [3:0]  sel = 4'h0;
    reg  [31:0] dat_w = 32'h0, rd, seed = 32'h5836f466, v;
    reg  [2:0]  osc = 3'h0;
    wire [31:0] dat_r;
    wire        ack, irq, tog;
    reg  [1:0]  m_src;
    reg  [2:0]  m_ps;
    reg         m_flag, m_ie, m_te, m_mask, m_tog;
    integer     m_cnt, m_cmp, m_buf, m_pre, n_mismatch = 0, cmp_count = 0, s, p, i;

    pmtc_top pmtc_top_inst (.CLOCK(clock), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
        .WB_ACK_O(ack), .EXT_OSC_CLK(osc[0]), .LOW_POWER_OSC_CLK(osc[1]),
        .INTERNAL_REF_CLK(osc[2]), .TICK_IRQ(irq), .TOGGLE_OUT(tog));

    initial forever #50 clock = ~clock;
    // ==================================================
    // Helpers
    function [31:0] xs;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            xs = seed;
        end
    endfunction
    function integer divisor(input [1:0] sr, input [2:0] ps);
        divisor = !sr[0] ? 1 << (ps - 1) : ps == 6 ? 100 : ps == 7 ? 1000 : 128 << (ps - 1);
    endfunction
    task chk_reg(input string n, input [31:0] e, input [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_pin(input string n, input e, input g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    // Request held until ack is sampled; one idle edge after release
    // No wait limit here: only the watchdog ends a lost answer
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hf, d};
            do begin
                @(posedge clock);
            end while (ack !== 1'b1);
            rd = dat_r;
            {cyc, stb} <= 2'b00;
            @(posedge clock);
        end
    endtask
    task wmod(input [15:0] m);
        m_buf = m;
        bus(1'b1, 8'h04, {16'h0, m});
    endtask
    task wctl(input [1:0] sr, input [2:0] ps, input [7:0] lo);
        if (sr != m_src || ps != m_ps) {m_cnt, m_pre} = 0;
        if (ps != 0) m_cmp = m_buf;
        if (lo[7]) m_flag = 0;
        {m_src, m_ps, m_ie, m_te} = {sr, ps, lo[6], lo[4]};
        bus(1'b1, 8'h00, {18'h0, sr, 1'b0, ps, lo});
    endtask
    // Model of one prescaler output tick
    task step;
        m_pre = 0;
        if (m_cnt == m_cmp) begin
            {m_cnt, m_flag, m_cmp} = {32'd0, 1'b1, m_buf};
            if (m_te) m_tog = ~m_tog;
        end else m_cnt++;
    endtask
    // Source edges spaced wide enough for the two-flop synchroniser
    task edges(input integer n);
        for (int j = 0; j < n; j++) begin
            osc[m_src] <= 1'b1;
            repeat (3) @(posedge clock);
            osc[m_src] <= 1'b0;
            repeat (3) @(posedge clock);
            if (m_ps != 0) m_pre++;
            if (m_ps != 0 && m_pre == divisor(m_src, m_ps)) step;
        end
        repeat (6) @(posedge clock);
    endtask
    task check_state;
        bus(1'b0, 8'h08, 32'h0);
        chk_reg("count", m_cnt, rd);
        bus(1'b0, 8'h0c, 32'h0);
        chk_reg("mask", {24'h0, m_mask, 7'h0}, rd);
        bus(1'b0, 8'h00, 32'h0);
        chk_reg("ctrl", {18'h0, m_src, 1'b0, m_ps, m_flag, m_ie, 1'b0, m_te, 4'h0}, rd);
        chk_pin("irq", m_flag & m_ie & !m_mask, irq);
        chk_pin("toggle", m_tog, tog);
    endtask
    task do_reset;
        reset_n <= 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        {m_src, m_ps, m_flag, m_ie, m_te, m_mask, m_tog} = 0;
        {m_cnt, m_cmp, m_buf, m_pre} = 0;
        @(posedge clock);
    endtask
    task tally_and_finish;
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clock);
        n_mismatch++;
        tally_and_finish;
    end
    // ==================================================
    // Scenarios
    initial begin
        do_reset;
        check_state;
        bus(1'b0, 8'h04, 32'h0);
        chk_reg("modulo", 32'h0, rd);
        bus(1'b0, 8'h10, 32'h0);
        chk_reg("unmapped", 32'h0, rd);
        for (i = 0; i < 6; i++) begin
            v = i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : xs();
            bus(1'b1, 8'h04, v);
            m_buf = v[15:0];
            bus(1'b0, 8'h04, 32'h0);
            chk_reg("modulo", {16'h0, v[15:0]}, rd);
        end
        bus(1'b1, 8'h08, 32'h1234);
        check_state;
        wmod(16'h3);
        wctl(2'h0, 3'h1, 8'h50);
        edges(2);
        wmod(16'h1);
        edges(2);
        check_state;
        edges(3);
        check_state;
        wctl(2'h0, 3'h1, 8'hd0);
        check_state;
        edges(1);
        wctl(2'h0, 3'h1, 8'h50);
        check_state;
        bus(1'b1, 8'h0c, 32'h80);
        m_mask = 1'b1;
        check_state;
        bus(1'b1, 8'h0c, 32'h0);
        m_mask = 1'b0;
        wctl(2'h0, 3'h1, 8'h10);
        check_state;
        wmod(16'h64);
        wctl(2'h0, 3'h1, 8'h10);
        edges(5);
        wctl(2'h0, 3'h2, 8'h10);
        check_state;
        wctl(2'h0, 3'h0, 8'h90);
        edges(4);
        check_state;
        // Modulo zero: the flag marks each prescaler tick exactly
        wmod(16'h0);
        for (s = 0; s < 3; s++) for (p = 1; p < 8; p++) begin
            wctl(s[1:0], p[2:0], 8'h90);
            edges(divisor(s[1:0], p[2:0]) - 1);
            check_state;
            edges(1);
            check_state;
        end
        wmod(16'hffff);
        wctl(2'h3, 3'h7, 8'h00);
        repeat (2500) @(posedge clock);
        m_cnt = 2;
        check_state;
        wctl(2'h2, 3'h7, 8'h00);
        check_state;
        do_reset;
        check_state;
        tally_and_finish;
    end
endmodule // pmtc_top_bench
